// >>> core/usm_pkg.sv
package usm_pkg;

  // Frame and divisor geometry.
  localparam int unsigned FRAME_BITS   = 8;
  localparam int unsigned DIV_WIDTH    = 12;
  localparam logic [1:0]  MODE_SPI_MST = 2'h3;

  // Reset values.
  localparam logic [11:0] DIV_RESET    = 12'h000;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [2:0]  BITCNT_LAST  = 3'h7;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    USM_IDLE = 3'b001,
    USM_LEAD = 3'b010,
    USM_TRAIL = 3'b100
  } usm_state_t;

endpackage

// >>> core/usm_spi_master.sv
`timescale 1ns/100ps
// How it works
// - With tx enabled the serial out pin carries the transmit shift register.
// - Rx enable routes the serial input pin into the receive shift register.
// - The transfer clock pin is the serial clock for every transfer.
// - A data register write starts a transfer that both sends and receives.
// - The buffered byte enters the shifter only when the shifter is free.
// - On receive overflow a parked third byte is overwritten by the next one, older bytes kept.
// - Receive complete, transmit complete and buffer empty behave as normal.
// - Frame error, overrun and parity error always read as zero.
// - Disabling tx or rx behaves as in asynchronous operation.
// - A transmit buffer sits ahead of the shift register.
// - Receive side holds two buffered bytes until read.
// - No write collision flag; writes go to the transmit buffer.
// - No double speed control; rate comes only from the divisor.
// - Master only: the block always makes the serial clock.
// - Polarity, phase and bit order behave as a standard SPI master.
// - No slave select pin; chip select is driven elsewhere.
// - The mode is active only when the mode select field is 2'b11.
// - Eight data bits per frame, order shared by transmit and receive.
// - Serial clock is system clock over two times (divisor plus one).
// - Data is set up on one clock edge and sampled on the other.
module usm_spi_master
(
  // Clock and reset.
  input  wire logic                 CLOCK,
  input  wire logic                 RESET_N,
  // Control bits.
  input  wire logic [1:0]           MODE_SELECT,
  input  wire logic                 TX_ENABLE,
  input  wire logic                 RX_ENABLE,
  input  wire logic                 CLOCK_POLARITY,
  input  wire logic                 CLOCK_PHASE,
  input  wire logic                 BIT_ORDER_LSB,
  input  wire logic [usm_pkg::DIV_WIDTH-1:0] BAUD_DIVISOR,
  // Data register access.
  input  wire logic                 DATA_WRITE,
  input  wire logic [7:0]           DATA_WDATA,
  input  wire logic                 DATA_READ,
  input  wire logic                 TX_COMPLETE_CLEAR,
  output logic      [7:0]           DATA_RDATA,
  // Status flags.
  output logic                      RX_COMPLETE,
  output logic                      TX_COMPLETE,
  output logic                      TX_BUFFER_EMPTY,
  output logic                      FRAME_ERROR,
  output logic                      OVERRUN,
  output logic                      PARITY_ERROR,
  // Serial pins; there is no slave select, chip select lives outside.
  input  wire logic                 SERIAL_IN,
  output logic                      SERIAL_OUT,
  output logic                      SERIAL_OUT_EN_N,
  output logic                      TRANSFER_CLOCK
);
  import usm_pkg::*;

  // Input pin synchroniser; only the second stage is read by logic.
  logic sin_meta;
  logic sin_sync;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sin_meta <= 1'b0;
      sin_sync <= 1'b0;
    end else begin
      sin_meta <= SERIAL_IN;
      sin_sync <= sin_meta;
    end
  end

  logic mode_on;
  logic tx_on;
  logic rx_on;
  assign mode_on = (MODE_SELECT == MODE_SPI_MST);
  assign tx_on   = mode_on && TX_ENABLE;
  assign rx_on   = mode_on && RX_ENABLE;

  // Datapath state.
  usm_state_t               state;
  usm_state_t               next_state;
  logic [DIV_WIDTH-1:0]     div_cnt;
  logic [DIV_WIDTH-1:0]     next_div_cnt;
  logic [2:0]               bit_cnt;
  logic [2:0]               next_bit_cnt;
  logic [7:0]               tx_shift;
  logic [7:0]               next_tx_shift;
  logic [7:0]               rx_shift;
  logic [7:0]               next_rx_shift;
  logic [7:0]               tx_buf;
  logic [7:0]               next_tx_buf;
  logic                     tx_full;
  logic                     next_tx_full;
  logic [7:0]               rx_buf0;
  logic [7:0]               next_rx_buf0;
  logic [7:0]               rx_buf1;
  logic [7:0]               next_rx_buf1;
  logic [7:0]               rx_hold;
  logic [7:0]               next_rx_hold;
  logic                     rx_held;
  logic                     next_rx_held;
  logic [1:0]               rx_count;
  logic [1:0]               next_rx_count;
  logic                     txc;
  logic                     next_txc;
  logic                     sclk;
  logic                     next_sclk;
  logic                     sout;
  logic                     next_sout;
  logic                     rx_push;
  logic [7:0]               rx_byte;
  logic                     tick;
  logic                     out_bit;

  // Half-period tick: divisor+1 system clocks per serial clock half.
  assign tick = (div_cnt == BAUD_DIVISOR);

  // Serial out is the bit at the head of the transmit shifter.
  assign out_bit = BIT_ORDER_LSB ? tx_shift[0] : tx_shift[7];

  // Next-state logic for sequencer, shifters, buffers and flags.
  always_comb begin
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_bit_cnt  = bit_cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_tx_buf   = tx_buf;
    next_tx_full  = tx_full;
    next_rx_buf0  = rx_buf0;
    next_rx_buf1  = rx_buf1;
    next_rx_count = rx_count;
    next_rx_hold  = rx_hold;
    next_rx_held  = rx_held;
    next_txc      = txc;
    next_sclk     = CLOCK_POLARITY;
    next_sout     = sout;
    rx_push       = 1'b0;
    rx_byte       = BIT_ORDER_LSB ? {sin_sync, rx_shift[7:1]} : {rx_shift[6:0], sin_sync};
    // Clearing the tx complete flag loses to a frame ending in the same cycle.
    if (TX_COMPLETE_CLEAR) begin
      next_txc = 1'b0;
    end
    // Writes land in the buffer only while it is empty; there is no collision flag.
    if (DATA_WRITE && tx_on && !tx_full) begin
      next_tx_buf  = DATA_WDATA;
      next_tx_full = 1'b1;
    end
    case (state)
      USM_IDLE: begin
        next_div_cnt = '0;
        next_sclk    = CLOCK_POLARITY;
        if (tx_full && tx_on) begin
          next_tx_shift = tx_buf;
          next_tx_full  = 1'b0;
          next_bit_cnt  = '0;
          next_state    = USM_LEAD;
          // Phase 0 puts the first bit out before the leading edge.
          next_sout     = BIT_ORDER_LSB ? tx_buf[0] : tx_buf[7];
        end
      end
      USM_LEAD: begin
        next_sclk    = ~CLOCK_POLARITY;
        next_div_cnt = tick ? '0 : div_cnt + 1'b1;
        if (!tx_on) begin
          next_state = USM_IDLE;
        end else if (tick) begin
          next_state = USM_TRAIL;
          next_sclk  = ~CLOCK_POLARITY;
          if (CLOCK_PHASE) begin
            next_sout = out_bit;
          end else if (rx_on) begin
            next_rx_shift = rx_byte;
          end
        end
      end
      USM_TRAIL: begin
        next_sclk    = CLOCK_POLARITY;
        next_div_cnt = tick ? '0 : div_cnt + 1'b1;
        if (!tx_on) begin
          next_state = USM_IDLE;
        end else if (tick) begin
          if (CLOCK_PHASE && rx_on) begin
            next_rx_shift = rx_byte;
          end
          next_tx_shift = BIT_ORDER_LSB ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
          next_bit_cnt  = bit_cnt + 3'h1;
          if (!CLOCK_PHASE) begin
            next_sout = BIT_ORDER_LSB ? tx_shift[1] : tx_shift[6];
          end
          if (bit_cnt == BITCNT_LAST) begin
            rx_push = rx_on;
            if (!(tx_full && tx_on)) begin
              next_state = USM_IDLE;
              next_txc   = 1'b1;
            end else begin
              // Back-to-back frame: reload straight from the buffer.
              next_tx_shift = tx_buf;
              next_tx_full  = 1'b0;
              next_state    = USM_LEAD;
              next_sout     = BIT_ORDER_LSB ? tx_buf[0] : tx_buf[7];
            end
          end else begin
            next_state = USM_LEAD;
          end
        end
      end
      default: begin
        next_state = USM_IDLE;
      end
    endcase
    // Receive FIFO of two; when full, a newer byte overwrites the parked one.
    if (DATA_READ && rx_count != 2'h0) begin
      next_rx_buf0  = rx_buf1;
      next_rx_count = rx_count - 2'h1;
      // A parked byte moves up behind the new head.
      if (rx_held) begin
        next_rx_buf1  = rx_hold;
        next_rx_count = rx_count;
        next_rx_held  = 1'b0;
      end
    end
    if (rx_push) begin
      if (next_rx_count == 2'h0) begin
        next_rx_buf0  = CLOCK_PHASE ? next_rx_shift : rx_shift;
        next_rx_count = 2'h1;
      end else if (next_rx_count == 2'h1) begin
        next_rx_buf1  = CLOCK_PHASE ? next_rx_shift : rx_shift;
        next_rx_count = 2'h2;
      end else begin
        // Full: the byte waits in the rx_hold register; a later arrival overwrites it.
        next_rx_hold  = CLOCK_PHASE ? next_rx_shift : rx_shift;
        next_rx_held  = 1'b1;
      end
    end
    // Disabling the receiver flushes the receive buffer.
    if (!rx_on) begin
      next_rx_count = 2'h0;
      next_rx_held  = 1'b0;
    end
    if (!tx_on) begin
      next_tx_full = 1'b0;
      next_sout    = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state    <= USM_IDLE;
      div_cnt  <= DIV_RESET;
      bit_cnt  <= 3'h0;
      tx_shift <= DATA_RESET;
      rx_shift <= DATA_RESET;
      tx_buf   <= DATA_RESET;
      tx_full  <= 1'b0;
      rx_buf0  <= DATA_RESET;
      rx_buf1  <= DATA_RESET;
      rx_count <= 2'h0;
      rx_hold  <= DATA_RESET;
      rx_held  <= 1'b0;
      txc      <= 1'b0;
      sclk     <= 1'b0;
      sout     <= 1'b1;
    end else begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      bit_cnt  <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      tx_buf   <= next_tx_buf;
      tx_full  <= next_tx_full;
      rx_buf0  <= next_rx_buf0;
      rx_buf1  <= next_rx_buf1;
      rx_count <= next_rx_count;
      rx_hold  <= next_rx_hold;
      rx_held  <= next_rx_held;
      txc      <= next_txc;
      sclk     <= next_sclk;
      sout     <= next_sout;
    end
  end

  // Output flops; error flags are constant zero in this mode.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      DATA_RDATA      <= DATA_RESET;
      RX_COMPLETE     <= 1'b0;
      TX_COMPLETE     <= 1'b0;
      TX_BUFFER_EMPTY <= 1'b1;
      FRAME_ERROR     <= 1'b0;
      OVERRUN         <= 1'b0;
      PARITY_ERROR    <= 1'b0;
      SERIAL_OUT      <= 1'b1;
      SERIAL_OUT_EN_N <= 1'b1;
      TRANSFER_CLOCK  <= 1'b0;
    end else begin
      DATA_RDATA      <= next_rx_buf0;
      RX_COMPLETE     <= (next_rx_count != 2'h0);
      TX_COMPLETE     <= next_txc;
      TX_BUFFER_EMPTY <= !next_tx_full;
      FRAME_ERROR     <= 1'b0;
      OVERRUN         <= 1'b0;
      PARITY_ERROR    <= 1'b0;
      SERIAL_OUT      <= next_sout;
      SERIAL_OUT_EN_N <= !tx_on;
      TRANSFER_CLOCK  <= next_sclk;
    end
  end

  // Checks.
  chk_errors_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !(FRAME_ERROR || OVERRUN || PARITY_ERROR)) else $error("error flag set");
  chk_mode_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (MODE_SELECT != MODE_SPI_MST) |=> $stable(tx_shift) || state == USM_IDLE)
    else $error("shift outside mode");
  chk_no_start_off: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == USM_IDLE && !tx_on) |=> state == USM_IDLE) else $error("start with tx off");
  chk_drive_pin: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    tx_on |=> !SERIAL_OUT_EN_N) else $error("serial out not driven");
  chk_load_free: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == USM_IDLE && tx_full && tx_on) |=> state == USM_LEAD && !tx_full)
    else $error("buffer not loaded");
  chk_write_buffer: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (DATA_WRITE && tx_on && !tx_full && state != USM_IDLE) |=> tx_full)
    else $error("write lost");
  chk_rx_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (rx_count == 2'h2 && !DATA_READ && rx_on) |=> rx_count == 2'h2 && $stable(rx_buf0))
    else $error("old byte lost");
  chk_idle_clock: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state == USM_IDLE && $past(state) == USM_IDLE) |-> TRANSFER_CLOCK == $past(CLOCK_POLARITY))
    else $error("idle clock level");
  chk_half_period: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (state != USM_IDLE) |-> div_cnt <= BAUD_DIVISOR) else $error("divider overrun");

endmodule

// >>> dv/usm_slave_model.sv
`timescale 1ns/100ps
// Behavioural serial slave; it sees the master clock through the system clock.
module usm_slave_model (
  // Clocking and select.
  input  wire logic       clk,
  input  wire logic       sel,
  // Mode of the attached master.
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  // Serial lines.
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Observation.
  output logic [7:0]      rx_byte,
  output int              n_frames
);
  logic       sck_q = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] r = 8'h4B;
  int         idx = 0;
  int         b = 0;
  initial begin
    miso = 1'b1;
    rx_byte = 8'h00;
    n_frames = 0;
  end
  // Acting just after the edge keeps us clear of the master's own sampling.
  always begin
    @(posedge clk);
    #1;
    if (sel && sck != sck_q) begin
      if ((sck != cpol) == !cpha) begin
        sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        idx++;
        if (idx == 8) begin
          rx_byte = sh;
          n_frames++;
          idx = 0;
        end
      end else begin
        // Setup edge: the reply bit only moves here, never on the sampling edge.
        b = idx;
        r = 8'(n_frames * 29 + 75);
      end
    end
    if (!sel) begin
      idx = 0;
      b = 0;
      r = 8'(n_frames * 29 + 75);
    end
    sck_q = sck;
    // A deselected line toggles so that a stale bit never reads as valid.
    miso = sel ? r[lsb ? b : 7 - b] : ~miso;
  end
endmodule

// >>> dv/usm_spi_master_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the serial master transfer block.
module usm_spi_master_tb_top;
  import usm_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  mode_select = MODE_SPI_MST;
  logic        tx_en = 1'b1, rx_en = 1'b1, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
  logic [11:0] div = 12'h003;
  logic        wr = 1'b0, rd = 1'b0, tcc = 1'b0, sel = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, slv_rx;
  logic        rxc, txc, tbe, fe, ovr, pe, so, so_en_n, sck, miso;
  logic [7:0]  flags;
  int          slv_n, mismatches = 0, n_checks = 0, nf = 0, seed = 32'h5C74;
  assign flags = {1'b0, so_en_n, rxc, txc, tbe, fe, ovr, pe};

  usm_spi_master u_usm_spi_master (.CLOCK(clock), .RESET_N(reset_n),
    .MODE_SELECT(mode_select), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en),
    .CLOCK_POLARITY(cpol), .CLOCK_PHASE(cpha), .BIT_ORDER_LSB(lsb),
    .BAUD_DIVISOR(div), .DATA_WRITE(wr), .DATA_WDATA(wdata), .DATA_READ(rd),
    .TX_COMPLETE_CLEAR(tcc), .DATA_RDATA(rdata), .RX_COMPLETE(rxc),
    .TX_COMPLETE(txc), .TX_BUFFER_EMPTY(tbe), .FRAME_ERROR(fe), .OVERRUN(ovr),
    .PARITY_ERROR(pe), .SERIAL_IN(miso), .SERIAL_OUT(so),
    .SERIAL_OUT_EN_N(so_en_n), .TRANSFER_CLOCK(sck));
  // The chip select lives here, outside the block under test.
  usm_slave_model u_usm_slave_model (.clk(clock), .sel(sel), .cpol(cpol),
    .cpha(cpha), .lsb(lsb), .sck(sck), .mosi(so), .miso(miso),
    .rx_byte(slv_rx), .n_frames(slv_n));

  // Free-running system clock.
  initial begin
    forever #2 clock = ~clock;
  end

  // Reply byte the slave sends in frame n.
  function automatic logic [7:0] rep(input int n);
    return 8'(n * 29 + 75);
  endfunction

  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic put(input logic [7:0] d);
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask

  // Checks the head of the receive buffer, then pops it.
  task automatic pop(input logic [7:0] e);
    check8("rdata", e, rdata);
    rd = 1'b1;
    tick();
    rd = 1'b0;
    tick();
  endtask

  // Bounded wait for the slave's frame count, then time for the master to finish the frame.
  task automatic wait_frames(input int t);
    for (int k = 0; slv_n < t; k++) begin
      if (k > 3000) begin
        mismatches++;
        $display("Error frames expected %0d seen %0d", t, slv_n);
        finish_test();
      end
      tick();
    end
    repeat (2 * div + 8) tick();
  endtask

  // One full frame with its checks.
  task automatic xfer(input logic [7:0] d);
    logic c;
    int   k;
    sel = 1'b1;
    tcc = 1'b1;
    tick();
    tcc = 1'b0;
    put(d);
    c = sck;
    for (k = 0; sck === c && k < 200; k++) tick();
    c = sck;
    for (k = 1; k < 200; k++) begin
      tick();
      if (sck !== c) break;
    end
    check8("half period", 8'(div + 1), 8'(k));
    nf++;
    wait_frames(nf);
    sel = 1'b0;
    check8("slave rx", d, slv_rx);
    check8("sck idle", {7'h0, cpol}, {7'h0, sck});
    check8("flags", {2'b0, rx_en, 5'h18}, flags);
    if (rx_en) pop(rep(nf - 1));
  endtask

  initial begin
    repeat (3) tick();
    check8("reset flags", 8'h48, flags);
    reset_n = 1'b1;
    tick();
    // All polarity, phase and order settings, twice, one frame without rx.
    for (int i = 0; i < 16; i++) begin
      {lsb, cpha, cpol} = 3'(i);
      rx_en = (i != 5);
      div = 12'(3 + {$random(seed)} % 4);
      repeat (4) tick();
      xfer(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed)));
    end
    // Four queued frames left unread: the third reply is the one lost.
    sel = 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; tbe !== 1'b1 && k < 300; k++) tick();
      put(8'($random(seed)));
      tick();
    end
    nf += 4;
    wait_frames(nf);
    sel = 1'b0;
    pop(rep(nf - 4));
    pop(rep(nf - 3));
    tick();
    pop(rep(nf - 1));
    check8("flags drained", 8'h18, flags);
    // Transmitter off, then wrong mode: a write must start nothing.
    sel = 1'b1;
    for (int m = 0; m < 2; m++) begin
      tx_en = m[0];
      mode_select = m[0] ? 2'h1 : MODE_SPI_MST;
      repeat (4) tick();
      put(8'hA5);
      repeat (60) tick();
      check8("no frame", 8'(nf), 8'(slv_n));
      check8("idle", 8'h03, {6'h0, tbe, so_en_n | tx_en});
    end
    finish_test();
  end
endmodule
